// ### fcl_cache.v
// Four-way set-associative physically tagged cache controller with
// lock-restricted replacement, one-line write-back buffer and mapped
// tag/data array access. Assumes the CPU holds a request until ack,
// the MMU gives the physical address with the request, and the memory
// bus controller runs on core_clk_i.
//
// How it works
// - Non-prefetch miss uses plain LRU unless a way-2 or way-3 lock applies
// - Way-2 lock alone: never way 2, fixed code table picks 3, 1 or 0
// - Way-3 lock alone: never way 3, fixed code table picks 2, 1 or 0
// - Both locks: top LRU bit 0 gives way 1, else way 0
// - Enabled cache indexes entries with virtual address bits 11-4
// - Hit needs physical tag match in any way with valid set
// - Read hit returns a 32-bit word and updates LRU
// - Read miss refills a 16-byte line, forwards the word, clean and valid
// - Prefetch hit only updates LRU, returns nothing
// - Prefetch miss uses load-aware victim choice, refills like read miss, returns nothing
// - Write-back write hit updates line, sets dirty, no bus write
// - Write-through write hit updates line and writes memory
// - Write-back miss evicts dirty victim to buffer, fills, writes, dirty
// - Write-through miss writes memory only
// - Buffer holds one line plus address; fills beat draining
// - Privileged longword non-fetch access to tag and data arrays
// - Tag access decodes entry 11-4, way 13-12, associative bit 3
// - Tag word: tag 31-10, LRU 9-4, dirty bit 1, valid bit 0
// - Tag read returns fields, never compares
// - Direct tag write writes back dirty valid line, then stores fields
// - Lock mode only while status word bit 12 is set
// - Associative tag write updates flags of hit way only
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "fcl_regs.vh"

module fcl_cache (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // CPU status word
    input wire [31:0] processor_status_word_i,
    // CPU request
    input wire cpu_req_i,
    input wire [31:0] cpu_vaddr_i,
    input wire [31:0] cpu_paddr_i,
    input wire cpu_we_i,
    input wire prefetch_instruction_i,
    input wire cpu_fetch_i,
    input wire cpu_priv_i,
    input wire cpu_long_i,
    input wire [31:0] cpu_wdata_i,
    output reg cpu_ack_o,
    output reg cpu_err_o,
    output reg [31:0] cpu_rdata_o,
    // External memory bus
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_LOOK = 5'h02;
    localparam [4:0] S_FILL = 5'h04;
    localparam [4:0] S_SINGLE = 5'h08;
    localparam [4:0] S_SPARE = 5'h10;

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg [21:0] tag_q [0:1023];
    reg [5:0] lru_q [0:255];
    reg [31:0] data_q [0:4095];
    reg [1023:0] valid_q;
    reg [1023:0] dirty_q;
    reg [31:0] wb_data_q [0:3];
    reg [27:0] wb_addr_q;
    reg wb_full_q;
    reg [1:0] wb_cnt_q;
    reg own_wb_q;

    reg [4:0] state_q;
    reg [31:0] r_va_q;
    reg [31:0] r_pa_q;
    reg [31:0] r_wd_q;
    reg r_we_q;
    reg r_prefetch_instruction_q;
    reg r_fetch_q;
    reg r_priv_q;
    reg r_long_q;
    reg [1:0] r_way_q;
    reg [1:0] fill_cnt_q;
    reg [31:0] ctrl_q;
    reg flush_pend_q;
    integer k;

    // ****************************************************************
    // Lookup
    // ****************************************************************
    wire [7:0] idx = r_va_q[11:4];
    wire mm = r_va_q[31:24] == `FCL_TAG_REGION ||
              r_va_q[31:24] == `FCL_DATA_REGION;
    wire mm_tag = r_va_q[31:24] == `FCL_TAG_REGION;
    wire mm_assoc = r_va_q[3];
    wire [1:0] mm_way = r_va_q[13:12];
    wire [21:0] cmp_tag = mm ? r_wd_q[31:10] : r_pa_q[31:10];
    wire lock_mode = processor_status_word_i[`FCL_LOCK_BIT];
    wire [3:0] hit;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cmp
            localparam [1:0] WAY = g;
            assign hit[g] = valid_q[{idx, WAY}] &&
                            tag_q[{idx, WAY}] == cmp_tag;
        end
    endgenerate
    wire any_hit = |hit;
    wire [1:0] hit_way = hit[0] ? 2'h0 : hit[1] ? 2'h1 :
                         hit[2] ? 2'h2 : 2'h3;
    wire [1:0] victim;
    wire [1:0] look_way = mm ? mm_way : victim;
    wire look_dv = valid_q[{idx, look_way}] & dirty_q[{idx, look_way}];
    wire hit_dv = valid_q[{idx, hit_way}] & dirty_q[{idx, hit_way}];
    wire wb_clash = wb_full_q && wb_addr_q == r_pa_q[31:4];
    wire [9:0] ti = {idx, r_way_q};
    wire main_bus = state_q == S_FILL || state_q == S_SINGLE;
    wire main_ack = mem_req_o & mem_ack_i & ~own_wb_q;

    fcl_victim u_victim (
        .lru_i(lru_q[idx]),
        .lock_mode_i(lock_mode),
        .way2_lock_i(ctrl_q[`FCL_CTRL_WAY2_LOCK]),
        .way2_load_request_i(ctrl_q[`FCL_CTRL_WAY2_LOAD_REQUEST]),
        .way3_lock_i(ctrl_q[`FCL_CTRL_WAY3_LOCK]),
        .way3_load_request_i(ctrl_q[`FCL_CTRL_WAY3_LOAD_REQUEST]),
        .prefetch_instruction_i(r_prefetch_instruction_q),
        .way_o(victim)
    );

    // Way just used becomes newest in every pair
    function [5:0] lru_touch;
        input [5:0] l;
        input [1:0] w;
        begin
            lru_touch = l;
            case (w)
                2'h0: lru_touch = {3'b000, l[2:0]};
                2'h1: lru_touch = {1'b1, l[4:3], 2'b00, l[0]};
                2'h2: lru_touch = {l[5], 1'b1, l[3], 1'b1, l[1], 1'b0};
                default: lru_touch = {l[5:4], 1'b1, l[2], 2'b11};
            endcase
        end
    endfunction

    // ****************************************************************
    // APB registers
    // ****************************************************************
    wire apb_acc = psel_i & penable_i;
    wire ctrl_hit = paddr_i == `FCL_CTRL_OFF;
    wire stat_hit = paddr_i == `FCL_STAT_OFF;

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `FCL_CTRL_RST;
            flush_pend_q <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            // Zero wait states: ready in the first access cycle
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~ctrl_hit & ~stat_hit;
            if (psel_i & ~penable_i & ~pwrite_i)
                prdata_o <= ctrl_hit ? {ctrl_q[31:3], 1'b0, ctrl_q[1:0]} :
                            stat_hit ? {30'h0, wb_full_q,
                                        state_q != S_IDLE} : 32'h0000_0000;
            if (apb_acc & pready_o & pwrite_i & ctrl_hit) begin
                ctrl_q <= pwdata_i & 32'h0003_0303;
                flush_pend_q <= pwdata_i[`FCL_CTRL_FLUSH];
            end else if (state_q == S_IDLE)
                flush_pend_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Controller, arrays and memory bus
    // ****************************************************************
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q <= S_IDLE;
            valid_q <= {1024{1'b0}};
            dirty_q <= {1024{1'b0}};
            wb_full_q <= 1'b0;
            wb_cnt_q <= 2'h0;
            wb_addr_q <= 28'h0;
            own_wb_q <= 1'b0;
            fill_cnt_q <= 2'h0;
            r_va_q <= 32'h0;
            r_pa_q <= 32'h0;
            r_wd_q <= 32'h0;
            r_we_q <= 1'b0;
            r_prefetch_instruction_q <= 1'b0;
            r_fetch_q <= 1'b0;
            r_priv_q <= 1'b0;
            r_long_q <= 1'b0;
            r_way_q <= 2'h0;
            cpu_ack_o <= 1'b0;
            cpu_err_o <= 1'b0;
            cpu_rdata_o <= 32'h0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h0;
            mem_wdata_o <= 32'h0;
        end else begin
            cpu_ack_o <= 1'b0;
            cpu_err_o <= 1'b0;
            // Bus engine; line fetches win over draining
            if (mem_req_o) begin
                if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    if (own_wb_q) begin
                        wb_cnt_q <= wb_cnt_q + 2'h1;
                        if (wb_cnt_q == 2'h3)
                            wb_full_q <= 1'b0;
                    end
                end
            end else if (main_bus) begin
                mem_req_o <= 1'b1;
                own_wb_q <= 1'b0;
                mem_we_o <= state_q == S_SINGLE && r_we_q;
                mem_addr_o <= state_q == S_FILL ?
                    {r_pa_q[31:4], fill_cnt_q, 2'b00} : r_pa_q;
                mem_wdata_o <= r_wd_q;
            end else if (wb_full_q) begin
                mem_req_o <= 1'b1;
                own_wb_q <= 1'b1;
                mem_we_o <= 1'b1;
                mem_addr_o <= {wb_addr_q, wb_cnt_q, 2'b00};
                mem_wdata_o <= wb_data_q[wb_cnt_q];
            end
            case (state_q)
                S_IDLE: begin
                    if (flush_pend_q) begin
                        valid_q <= {1024{1'b0}};
                        dirty_q <= {1024{1'b0}};
                    end else if (cpu_req_i && !cpu_ack_o) begin
                        r_va_q <= cpu_vaddr_i;
                        r_pa_q <= cpu_paddr_i;
                        r_wd_q <= cpu_wdata_i;
                        r_we_q <= cpu_we_i;
                        r_prefetch_instruction_q <= prefetch_instruction_i;
                        r_fetch_q <= cpu_fetch_i;
                        r_priv_q <= cpu_priv_i;
                        r_long_q <= cpu_long_i;
                        state_q <= S_LOOK;
                    end
                end
                S_LOOK: begin
                    r_way_q <= look_way;
                    fill_cnt_q <= 2'h0;
                    if (mm && (r_fetch_q || !r_priv_q || !r_long_q)) begin
                        cpu_err_o <= 1'b1;
                        cpu_ack_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (mm && !mm_tag) begin
                        if (r_we_q)
                            data_q[{mm_way, idx, r_va_q[3:2]}] <= r_wd_q;
                        else
                            cpu_rdata_o <=
                                data_q[{mm_way, idx, r_va_q[3:2]}];
                        cpu_ack_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (mm && !r_we_q) begin
                        cpu_rdata_o <= {tag_q[{idx, mm_way}],
                            lru_q[idx], 2'b00, dirty_q[{idx, mm_way}],
                            valid_q[{idx, mm_way}]};
                        cpu_ack_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (mm && !mm_assoc) begin
                        // Busy buffer stalls the write over a dirty valid way until drained
                        if (!(look_dv && wb_full_q)) begin
                            if (look_dv) begin
                                wb_addr_q <= {tag_q[{idx, mm_way}],
                                              idx[5:0]};
                                for (k = 0; k < 4; k = k + 1)
                                    wb_data_q[k] <= data_q[{mm_way, idx,
                                                          k[1:0]}];
                                wb_full_q <= 1'b1;
                                wb_cnt_q <= 2'h0;
                            end
                            tag_q[{idx, mm_way}] <= r_wd_q[31:10];
                            lru_q[idx] <= r_wd_q[9:4];
                            dirty_q[{idx, mm_way}] <= r_wd_q[1];
                            valid_q[{idx, mm_way}] <= r_wd_q[0];
                            cpu_ack_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end else if (mm) begin
                        if (!(any_hit && hit_dv && wb_full_q)) begin
                            if (any_hit) begin
                                if (hit_dv) begin
                                    wb_addr_q <= {tag_q[{idx, hit_way}],
                                                  idx[5:0]};
                                    for (k = 0; k < 4; k = k + 1)
                                        wb_data_q[k] <= data_q[{hit_way,
                                                      idx, k[1:0]}];
                                    wb_full_q <= 1'b1;
                                    wb_cnt_q <= 2'h0;
                                end
                                dirty_q[{idx, hit_way}] <= r_wd_q[1];
                                valid_q[{idx, hit_way}] <= r_wd_q[0];
                            end
                            cpu_ack_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end else if (!ctrl_q[`FCL_CTRL_ENABLE]) begin
                        if (!wb_clash)
                            state_q <= S_SINGLE;
                    end else if (any_hit) begin
                        lru_q[idx] <= lru_touch(lru_q[idx], hit_way);
                        if (r_prefetch_instruction_q) begin
                            cpu_ack_o <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (r_we_q) begin
                            data_q[{hit_way, idx, r_va_q[3:2]}] <= r_wd_q;
                            if (ctrl_q[`FCL_CTRL_WTHRU])
                                state_q <= S_SINGLE;
                            else begin
                                dirty_q[{idx, hit_way}] <= 1'b1;
                                cpu_ack_o <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end else begin
                            cpu_rdata_o <=
                                data_q[{hit_way, idx, r_va_q[3:2]}];
                            cpu_ack_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end else if (r_we_q && ctrl_q[`FCL_CTRL_WTHRU]) begin
                        if (!wb_clash)
                            state_q <= S_SINGLE;
                    end else if (!wb_clash && !(look_dv && wb_full_q)) begin
                        if (look_dv) begin
                            wb_addr_q <= {tag_q[{idx, victim}], idx[5:0]};
                            for (k = 0; k < 4; k = k + 1)
                                wb_data_q[k] <= data_q[{victim, idx,
                                                      k[1:0]}];
                            wb_full_q <= 1'b1;
                            wb_cnt_q <= 2'h0;
                        end
                        state_q <= S_FILL;
                    end
                end
                S_FILL: begin
                    if (main_ack) begin
                        fill_cnt_q <= fill_cnt_q + 2'h1;
                        if (r_we_q && fill_cnt_q == r_va_q[3:2])
                            data_q[{r_way_q, idx, fill_cnt_q}] <= r_wd_q;
                        else
                            data_q[{r_way_q, idx, fill_cnt_q}] <=
                                mem_rdata_i;
                        if (!r_we_q && !r_prefetch_instruction_q &&
                            fill_cnt_q == r_va_q[3:2]) begin
                            cpu_rdata_o <= mem_rdata_i;
                            cpu_ack_o <= 1'b1;
                        end
                        if (fill_cnt_q == 2'h3) begin
                            tag_q[ti] <= r_pa_q[31:10];
                            valid_q[ti] <= 1'b1;
                            dirty_q[ti] <= r_we_q;
                            lru_q[idx] <= lru_touch(lru_q[idx],
                                                    r_way_q);
                            if (r_we_q || r_prefetch_instruction_q)
                                cpu_ack_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_SINGLE: begin
                    if (main_ack) begin
                        if (!r_we_q)
                            cpu_rdata_o <= mem_rdata_i;
                        cpu_ack_o <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule // fcl_cache

// ### fcl_regs.vh
// Constants for the four-way cache controller: register offsets,
// control field positions, mapped-region codes and reset values.
// Assumes it is included by bare name from the controller files.
`ifndef FCL_REGS_VH
`define FCL_REGS_VH

// ****************************************************************
// APB register map
// ****************************************************************
`define FCL_CTRL_OFF 8'h00
`define FCL_STAT_OFF 8'h04
`define FCL_CTRL_RST 32'h0000_0000

// ****************************************************************
// Control fields
// ****************************************************************
`define FCL_CTRL_ENABLE 0
`define FCL_CTRL_WTHRU 1
`define FCL_CTRL_FLUSH 2
`define FCL_CTRL_WAY2_LOCK 8
`define FCL_CTRL_WAY2_LOAD_REQUEST 9
`define FCL_CTRL_WAY3_LOCK 16
`define FCL_CTRL_WAY3_LOAD_REQUEST 17

// ****************************************************************
// Status fields
// ****************************************************************
`define FCL_STAT_BUSY 0
`define FCL_STAT_WBFULL 1

// ****************************************************************
// Mapped cache arrays and lock mode
// ****************************************************************
`define FCL_TAG_REGION 8'hF0
`define FCL_DATA_REGION 8'hF1
`define FCL_LOCK_BIT 12

`endif

// ### fcl_victim.v
// Victim way selection from the six-bit LRU code and lock controls.
// Assumes lock_mode_i is already qualified by the status word bit.
`timescale 1ns/1ps

module fcl_victim (
    // LRU code of the indexed entry
    input wire [5:0] lru_i,
    // Lock controls
    input wire lock_mode_i,
    input wire way2_lock_i,
    input wire way2_load_request_i,
    input wire way3_lock_i,
    input wire way3_load_request_i,
    input wire prefetch_instruction_i,
    // Selected way
    output reg [1:0] way_o
);

    wire l2 = lock_mode_i & way2_lock_i;
    wire l3 = lock_mode_i & way3_lock_i;
    reg [1:0] norm;
    reg [1:0] lk2;
    reg [1:0] lk3;

    always @* begin
        // Normal pairwise LRU decode
        if (lru_i[5] & lru_i[4] & lru_i[3])
            norm = 2'h0;
        else if (!lru_i[5] & lru_i[2] & lru_i[1])
            norm = 2'h1;
        else if (!lru_i[4] & !lru_i[2] & lru_i[0])
            norm = 2'h2;
        else
            norm = 2'h3;
        case (lru_i)
            6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34: lk2 = 2'h3;
            6'h29, 6'h2B, 6'h38, 6'h39, 6'h3B, 6'h3C, 6'h3E, 6'h3F: lk2 = 2'h0;
            default: lk2 = 2'h1;
        endcase
        case (lru_i)
            6'h00, 6'h01, 6'h03, 6'h0B, 6'h20, 6'h21, 6'h29, 6'h2B: lk3 = 2'h2;
            6'h30, 6'h34, 6'h38, 6'h39, 6'h3B, 6'h3C, 6'h3E, 6'h3F: lk3 = 2'h0;
            default: lk3 = 2'h1;
        endcase
        // Load bits only steer prefetch misses
        if (prefetch_instruction_i && lock_mode_i && way2_load_request_i &&
            way2_lock_i && !way3_load_request_i)
            way_o = 2'h2;
        else if (prefetch_instruction_i && lock_mode_i &&
                 way3_load_request_i && way3_lock_i && !way2_load_request_i)
            way_o = 2'h3;
        else if (l2 && l3)
            way_o = lru_i[5] ? 2'h0 : 2'h1;
        else if (l2)
            way_o = lk2;
        else if (l3)
            way_o = lk3;
        else
            way_o = norm;
    end

endmodule // fcl_victim

// ### fcl_mem_model.sv
// Behavioural memory bus controller facing the cache controller.
// Assumes one request at a time and answers after 0 to 3 wait cycles.
`timescale 1ns/1ps
module fcl_mem_model (
    // Clock, reset and bus
    input wire core_clk_i, rst_n_i, req_i, we_i,
    input wire [31:0] addr_i, wdata_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0] wait_q, lat_q;
    always @(posedge core_clk_i) begin
        ack_o <= 1'b0;
        // Never leave a stale word on the line between answers
        rdata_o <= ~rdata_o;
        if (!rst_n_i) begin
            {wait_q, lat_q, rdata_o} <= 36'h0;
        end else if (req_i && !ack_o) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == lat_q) begin
                {ack_o, wait_q, lat_q} <= {3'h4, lat_q + 2'h1};
                if (we_i) mem[addr_i] = wdata_i;
                rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i;
            end
        end
    end
endmodule // fcl_mem_model

// ### fcl_cache_chk.sv
// Port checker for the cache controller, bound into each instance.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module fcl_cache_chk (
    // Watched ports
    input wire core_clk_i, rst_n_i, cpu_req_i, cpu_fetch_i, cpu_ack_o,
    input wire cpu_err_o, mem_req_o, mem_we_o, mem_ack_i,
    input wire [31:0] cpu_vaddr_i, cpu_rdata_o, mem_addr_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_one; cpu_ack_o |=> !cpu_ack_o; endproperty
    a_one: assert property (p_one) else $error("ack too long");
    property p_req; cpu_ack_o |-> cpu_req_i; endproperty
    a_req: assert property (p_req) else $error("ack unasked");
    property p_due; cpu_req_i && !cpu_ack_o |-> ##[0:600] cpu_ack_o;
    endproperty
    a_due: assert property (p_due) else $error("no answer");
    property p_err; cpu_err_o |-> cpu_ack_o; endproperty
    a_err: assert property (p_err) else $error("err without ack");
    property p_map; cpu_ack_o && cpu_fetch_i && cpu_vaddr_i[31:25] == 7'h78
        |-> cpu_err_o; endproperty
    a_map: assert property (p_map) else $error("mapped fetch taken");
    property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_addr_o) && $stable(mem_we_o); endproperty
    a_hold: assert property (p_hold) else $error("bus request moved");
    property p_gap; mem_req_o && mem_ack_i |=> !mem_req_o; endproperty
    a_gap: assert property (p_gap) else $error("no bus gap");
    property p_keep; cpu_ack_o |=> $stable(cpu_rdata_o); endproperty
    a_keep: assert property (p_keep) else $error("read data moved");
    c_err: cover property (cpu_err_o);
    c_wb: cover property (mem_req_o && mem_we_o && mem_ack_i);
    c_slow: cover property (mem_req_o && !mem_ack_i [*3]);
endmodule // fcl_cache_chk
bind fcl_cache fcl_cache_chk i_fcl_cache_chk (.core_clk_i, .rst_n_i,
    .cpu_req_i, .cpu_fetch_i, .cpu_ack_o, .cpu_err_o, .mem_req_o,
    .mem_we_o, .mem_ack_i, .cpu_vaddr_i, .cpu_rdata_o, .mem_addr_o);

// ### tb.sv
// Self-checking bench: random cached traffic, registers, mapped arrays.
// Assumes the memory model starts with each word equal to ~address.
`timescale 1ns/1ps
module tb;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, cpu_req_i = 1'b0, cpu_we_i = 1'b0;
    logic prefetch_instruction_i = 1'b0, cpu_fetch_i = 1'b0;
    logic cpu_priv_i = 1'b0, cpu_long_i = 1'b0, e;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, processor_status_word_i = 32'h0;
    logic [31:0] cpu_vaddr_i = 32'h0, cpu_paddr_i = 32'h0, cpu_wdata_i = 32'h0;
    logic [31:0] prdata_o, cpu_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic pready_o, pslverr_o, cpu_ack_o, cpu_err_o, mem_req_o, mem_we_o;
    logic mem_ack_i;
    logic [31:0] r, keep [2];
    logic [31:0] shadow [logic [31:0]];
    int err_count = 0, compares = 0, cyc = 0;
    fcl_cache i_fcl_cache (.*);
    fcl_mem_model i_fcl_mem_model (.core_clk_i, .rst_n_i, .req_i(mem_req_o),
        .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) give_verdict(1);
    end
    // Five tags on two entries force evictions
    function automatic logic [31:0] adr(int j);
        return 32'h0010_0000 + (j % 5) * 32'h1000 + (j / 5 % 2) * 32'h10
            + (j / 10 % 4) * 32'h4;
    endfunction
    function automatic logic [31:0] ex(logic [31:0] a);
        return shadow.exists(a) ? shadow[a] : ~a;
    endfunction
    task automatic chk(string nm, logic [31:0] x, g);
        compares++;
        err_count += int'(g !== x);
        if (g !== x) $display("[ERR] %s expected %h seen %h", nm, x, g);
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        {r, e} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic cpu(logic [4:0] k, logic [31:0] pa, d);
        @(posedge core_clk_i);
        {cpu_we_i, prefetch_instruction_i, cpu_fetch_i, cpu_priv_i, cpu_long_i,
            cpu_paddr_i, cpu_wdata_i, cpu_req_i} <= {k, pa, d, 1'b1};
        cpu_vaddr_i <= pa[31:28] == 4'hF ? pa : pa ^ 32'h4000_0000;
        do @(posedge core_clk_i); while (cpu_ack_o !== 1'b1);
        {r, e} = {cpu_rdata_o, cpu_err_o};
        cpu_req_i <= 1'b0;
    endtask
    task automatic run(int n);
        logic [31:0] pa, d;
        repeat (n) begin
            pa = adr($urandom % 40);
            d = $urandom;
            cpu(d[0] ? 5'h13 : d[1] ? 5'h0B : 5'h03, pa, d);
            if (d[0]) shadow[pa] = d;
            else if (!d[1]) chk("read", ex(pa), r);
        end
    endtask
    task automatic ways(logic [1:0] cmp);
        for (int w = 0; w < 2; w++) begin
            cpu(5'h03, 32'hF000_2000 + w * 32'h1000, 32'h0);
            if (cmp[w]) chk("locked way", keep[w], r & 32'hFFFF_FC01);
            keep[w] = r & 32'hFFFF_FC01;
        end
    endtask
    task automatic give_verdict(int late);
        err_count += late;
        $display("Compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h68a1));
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, 8'h0C, 32'h0);
        chk("bad offset", 32'h1, {31'h0, e});
        apb(1'b1, 8'h00, 32'h3);
        run(100);
        apb(1'b1, 8'h00, 32'h1);
        run(150);
        ways(2'b00);
        processor_status_word_i <= 32'h0000_1000;
        apb(1'b1, 8'h00, 32'h0001_0101);
        run(150);
        ways(2'b11);
        apb(1'b1, 8'h00, 32'h0000_0101);
        run(60);
        ways(2'b01);
        apb(1'b1, 8'h00, 32'h0001_0001);
        run(60);
        ways(2'b10);
        $display("Cached traffic done");
        for (int j = 0; j < 10; j++)
            cpu(5'h13, 32'hF000_0008 | adr(j) & 32'hFF0, adr(j) & 32'hFFFF_FC00);
        apb(1'b1, 8'h00, 32'h0);
        do apb(1'b0, 8'h04, 32'h0); while (r[1] !== 1'b0);
        for (int j = 0; j < 40; j++) begin
            cpu(5'h03, adr(j), 32'h0);
            chk("memory", ex(adr(j)), r);
        end
        apb(1'b1, 8'h00, 32'h1);
        for (int i = 0; i < 3; i++) begin
            cpu(i == 0 ? 5'h07 : i == 1 ? 5'h01 : 5'h02, 32'hF000_0000, 32'h0);
            chk("refused", 32'h1, {31'h0, e});
        end
        keep[0] = $urandom & 32'h1FFF_FC00 | 32'h1;
        cpu(5'h13, 32'hF000_1050, keep[0]);
        cpu(5'h03, 32'hF000_1058, 32'h0);
        chk("tag word", keep[0], r);
        $display("Mapped access done");
        give_verdict(0);
    end
endmodule // tb
